// ===== cpc_pkg.sv
// constants, encodings and states of the configuration pin controller
// assumes one 25 MHz system clock; only the 45 bits through the synchroniser arrive unsynchronised
package cpc_pkg;
   localparam int unsigned SYS_CLK_HZ = 25_000_000;
   localparam int unsigned ACT_CLK_HZ = 6_250_000;
   localparam logic [3:0]  ACT_HALF   = 4'(SYS_CLK_HZ / (2 * ACT_CLK_HZ));
   localparam int unsigned SYNC_W     = 45;
   // idle level per synchronised pin: tck rests high
   localparam logic [44:0] SYNC_IDLE  = {32'h0000_0000, 13'h0100};
   localparam logic [5:0]  WORD_BITS  = 6'h20;
   localparam logic [1:0]  WID_X1     = 2'h0;
   localparam logic [1:0]  WID_X4     = 2'h1;
   localparam logic [1:0]  WID_X8     = 2'h2;
   localparam logic [1:0]  WID_X32    = 2'h3;
   localparam logic [3:0]  IR_IDCODE  = 4'h1;
   localparam logic [3:0]  IR_BYPASS  = 4'hf;
   localparam logic [3:0]  IR_CAPTURE = 4'h1;
   // arbitrary identity value
   localparam logic [31:0] ID_VALUE   = 32'h1234_5671;

   typedef enum logic [2:0] {
      C_IDLE  = 3'b000,
      C_WSEL  = 3'b001,
      C_LOAD  = 3'b010,
      C_WDONE = 3'b011,
      C_USER  = 3'b100,
      C_ERR   = 3'b101
   } cpc_cfg_t;

   typedef enum logic [3:0] {
      T_RST = 4'b0000, T_RTI = 4'b0001, T_SDS = 4'b0010, T_CDR = 4'b0011,
      T_SHD = 4'b0100, T_E1D = 4'b0101, T_PDR = 4'b0110, T_E2D = 4'b0111,
      T_UDR = 4'b1000, T_SIS = 4'b1001, T_CIR = 4'b1010, T_SHI = 4'b1011,
      T_E1I = 4'b1100, T_PIR = 4'b1101, T_E2I = 4'b1110, T_UIR = 4'b1111
   } cpc_tap_t;
endpackage : cpc_pkg

// ===== cpc_top.sv
// configuration pin controller: load sequencing, pin directions, test port
// assumes core logic flags image end and errors on sys_clk_in
`timescale 1ns/1ps
module cpc_top (
   input  wire logic        sys_clk_in,
   input  wire logic        rst_b_in,
   input  wire logic        clk_en_in,
   input  wire logic        reconfig_reset_n_in,
   input  wire logic        mode_strap_flash_cs_n_in,
   input  wire logic [1:0]  image_select_strap_in,
   input  wire logic        multi_image_in,
   input  wire logic        remote_reconfig_in,
   input  wire logic [1:0]  remote_image_in,
   input  wire logic        device_select_in,
   input  wire logic        config_clock_pin_in,
   input  wire logic        alt_active_clock_in,
   input  wire logic        alt_clock_sel_in,
   input  wire logic [1:0]  data_width_in,
   input  wire logic [31:0] config_data_line_in,
   input  wire logic        config_done_od_in,
   input  wire logic        image_loaded_in,
   input  wire logic        id_mismatch_in,
   input  wire logic        crc_fail_in,
   input  wire logic        remote_fail_in,
   input  wire logic        tck_in,
   input  wire logic        tms_in,
   input  wire logic        tms_undriven_in,
   input  wire logic        tdi_in,
   input  wire logic        tdi_undriven_in,
   output logic             config_done_od_out,
   output logic             config_done_od_oe_out,
   output logic             config_error_n_out,
   output logic             device_select_out,
   output logic             user_mode_out,
   output logic             active_mode_out,
   output logic [1:0]       image_index_out,
   output logic             mode_strap_flash_cs_n_out,
   output logic             mode_strap_flash_cs_n_oe_out,
   output logic             upper_flash_cs_n_out,
   output logic             upper_flash_cs_n_oe_out,
   output logic             config_clock_pin_out,
   output logic             config_clock_pin_oe_out,
   output logic             config_data_line0_out,
   output logic             config_data_line0_oe_out,
   output logic [31:0]      cfg_word_out,
   output logic             cfg_word_valid_out,
   output logic             tdo_out,
   output logic             tdo_oe_out
);
   logic [cpc_pkg::SYNC_W-1:0] raw;
   logic [cpc_pkg::SYNC_W-1:0] s1;
   logic [cpc_pkg::SYNC_W-1:0] s2;
   logic        rst_n_s, mode_s, dsel_s, cck_s, alt_s, done_s;
   logic        tck_s, tms_s, tmsz_s, tdi_s, tdiz_s;
   logic [1:0]  img_s;
   logic [31:0] data_s;

   cpc_pkg::cpc_cfg_t st, next_st;
   logic        mode_act, next_mode_act;
   logic [1:0]  img, next_img;
   logic [31:0] sh, next_sh;
   logic [5:0]  cnt, next_cnt;
   logic [3:0]  div, next_div;
   logic        cko, next_cko;
   logic        prv_rst, next_prv_rst;
   logic        prv_cck, next_prv_cck;
   logic        prv_alt, next_prv_alt;
   logic        wvalid, next_wvalid;
   logic [31:0] word, next_word;
   logic        done_oe, next_done_oe;
   logic        err_n, next_err_n;
   logic        dsel_o, next_dsel_o;
   logic        user, next_user;
   logic        cs_l, next_cs_l;
   logic        cs_l_oe, next_cs_l_oe;
   logic        cs_u, next_cs_u;
   logic        cs_u_oe, next_cs_u_oe;
   logic        cko_oe, next_cko_oe;
   logic        d0_oe, next_d0_oe;
   logic        rst_rise, take, loading;
   logic [5:0]  step;

   cpc_pkg::cpc_tap_t tap, next_tap;
   logic [3:0]  ir, next_ir;
   logic [3:0]  ir_sh, next_ir_sh;
   logic [31:0] dr, next_dr;
   logic        prv_tck, next_prv_tck;
   logic        tdo, next_tdo;
   logic        tdo_oe, next_tdo_oe;
   logic        tck_rise, tck_fall, tms_e, tdi_e;

   assign raw = {config_data_line_in, tdi_undriven_in, tdi_in,
                 tms_undriven_in, tms_in, tck_in, config_done_od_in,
                 alt_active_clock_in, config_clock_pin_in,
                 device_select_in, image_select_strap_in,
                 mode_strap_flash_cs_n_in, reconfig_reset_n_in};
   assign {data_s, tdiz_s, tdi_s, tmsz_s, tms_s, tck_s, done_s,
           alt_s, cck_s, dsel_s, img_s, mode_s, rst_n_s} = s2;

   genvar g;
   generate
      for (g = 0; g < cpc_pkg::SYNC_W; g++) begin : g_sync
         always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
            if (!rst_b_in) begin
               s1[g] <= cpc_pkg::SYNC_IDLE[g];
               s2[g] <= cpc_pkg::SYNC_IDLE[g];
            end else if (clk_en_in) begin
               s1[g] <= raw[g];
               s2[g] <= s1[g];
            end
         end
      end
   endgenerate

   always_comb begin
      next_st      = st;
      next_mode_act = mode_act;
      next_img     = img;
      next_sh      = sh;
      next_cnt     = cnt;
      next_div     = 4'h0;
      next_cko     = 1'b0;
      next_wvalid  = 1'b0;
      next_word    = word;
      next_prv_rst = rst_n_s;
      next_prv_cck = cck_s;
      next_prv_alt = alt_s;
      rst_rise     = rst_n_s & ~prv_rst;
      loading      = (st == cpc_pkg::C_LOAD);
      take         = 1'b0;
      step         = 6'h01;
      if (!mode_act) begin
         take = cck_s & ~prv_cck;
      end else if (alt_clock_sel_in) begin
         next_cko = loading & alt_s;
         take     = loading & alt_s & ~prv_alt;
      end else if (loading) begin
         next_cko = cko;
         next_div = 4'(div + 4'h1);
         if (div == cpc_pkg::ACT_HALF - 4'h1) begin
            next_div = 4'h0;
            next_cko = ~cko;
            take     = ~cko;
         end
      end
      case (data_width_in)
         cpc_pkg::WID_X1: begin
            step = 6'h01;
            next_sh = {sh[30:0], mode_act ? data_s[1] : data_s[0]};
         end
         cpc_pkg::WID_X4: begin
            step    = 6'h04;
            next_sh = {sh[27:0], data_s[3:0]};
         end
         cpc_pkg::WID_X8: begin
            step    = 6'h08;
            next_sh = {sh[23:0], data_s[7:0]};
         end
         default: begin
            step    = cpc_pkg::WORD_BITS;
            next_sh = data_s;
         end
      endcase
      case (st)
         cpc_pkg::C_IDLE: begin
            if (rst_rise) begin
               next_mode_act = mode_s;
               next_img = multi_image_in ? img_s : 2'h0;
               next_cnt = 6'h00;
               next_st  = dsel_s ? cpc_pkg::C_LOAD : cpc_pkg::C_WSEL;
            end
         end
         cpc_pkg::C_WSEL: begin
            if (dsel_s) begin
               next_st = cpc_pkg::C_LOAD;
            end
         end
         cpc_pkg::C_LOAD: begin
            if (id_mismatch_in || crc_fail_in || remote_fail_in) begin
               next_st = cpc_pkg::C_ERR;
            end else if (image_loaded_in) begin
               next_st = cpc_pkg::C_WDONE;
            end
         end
         cpc_pkg::C_WDONE: begin
            if (id_mismatch_in || crc_fail_in || remote_fail_in) begin
               next_st = cpc_pkg::C_ERR;
            end else if (done_s) begin
               next_st = cpc_pkg::C_USER;
            end
         end
         cpc_pkg::C_USER: begin
            if (remote_reconfig_in) begin
               next_img = remote_image_in;
               next_cnt = 6'h00;
               next_st  = cpc_pkg::C_LOAD;
            end
         end
         default: begin
            next_st = cpc_pkg::C_ERR;
         end
      endcase
      if (!(loading && take && dsel_s)) begin
         next_sh = sh;
      end else if (6'(cnt + step) == cpc_pkg::WORD_BITS) begin
         next_cnt    = 6'h00;
         next_word   = next_sh;
         next_wvalid = 1'b1;
      end else begin
         next_cnt = 6'(cnt + step);
      end
      if (!rst_n_s) begin
         next_st = cpc_pkg::C_IDLE;
      end
      next_done_oe = !(next_st inside {cpc_pkg::C_WDONE, cpc_pkg::C_USER});
      next_user    = (next_st == cpc_pkg::C_USER);
      next_dsel_o  = next_user;
      next_err_n   = (next_st != cpc_pkg::C_ERR);
      next_cs_l    = !(next_mode_act && next_st == cpc_pkg::C_LOAD);
      next_cs_l_oe = next_mode_act && !next_user && next_st != cpc_pkg::C_IDLE;
      next_cs_u    = !(next_cs_l == 1'b0 && data_width_in == cpc_pkg::WID_X8);
      next_cs_u_oe = next_cs_l_oe && data_width_in == cpc_pkg::WID_X8;
      next_cko_oe  = next_mode_act && next_st == cpc_pkg::C_LOAD;
      // line 0 driven only in x1
      next_d0_oe   = next_cko_oe && data_width_in == cpc_pkg::WID_X1;
   end

   always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         st       <= cpc_pkg::C_IDLE;
         mode_act <= 1'b0;
         img      <= 2'h0;
         sh       <= 32'h0000_0000;
         cnt      <= 6'h00;
         div      <= 4'h0;
         cko      <= 1'b0;
         prv_rst  <= 1'b0;
         prv_cck  <= 1'b0;
         prv_alt  <= 1'b0;
         wvalid   <= 1'b0;
         word     <= 32'h0000_0000;
         done_oe  <= 1'b1;
         err_n    <= 1'b1;
         dsel_o   <= 1'b0;
         user     <= 1'b0;
         cs_l     <= 1'b1;
         cs_l_oe  <= 1'b0;
         cs_u     <= 1'b1;
         cs_u_oe  <= 1'b0;
         cko_oe   <= 1'b0;
         d0_oe    <= 1'b0;
      end else if (clk_en_in) begin
         st       <= next_st;
         mode_act <= next_mode_act;
         img      <= next_img;
         sh       <= next_sh;
         cnt      <= next_cnt;
         div      <= next_div;
         cko      <= next_cko;
         prv_rst  <= next_prv_rst;
         prv_cck  <= next_prv_cck;
         prv_alt  <= next_prv_alt;
         wvalid   <= next_wvalid;
         word     <= next_word;
         done_oe  <= next_done_oe;
         err_n    <= next_err_n;
         dsel_o   <= next_dsel_o;
         user     <= next_user;
         cs_l     <= next_cs_l;
         cs_l_oe  <= next_cs_l_oe;
         cs_u     <= next_cs_u;
         cs_u_oe  <= next_cs_u_oe;
         cko_oe   <= next_cko_oe;
         d0_oe    <= next_d0_oe;
      end
   end

   // test port state and registers
   always_comb begin
      next_prv_tck = tck_s;
      tck_rise     = tck_s & ~prv_tck;
      tck_fall     = ~tck_s & prv_tck;
      tms_e        = tms_s | tmsz_s;
      tdi_e        = tdi_s | tdiz_s;
      next_tap     = tap;
      next_ir      = ir;
      next_ir_sh   = ir_sh;
      next_dr      = dr;
      next_tdo     = tdo;
      next_tdo_oe  = tdo_oe;
      if (tck_rise) begin
         case (tap)
            cpc_pkg::T_RST: next_tap = tms_e ? cpc_pkg::T_RST : cpc_pkg::T_RTI;
            cpc_pkg::T_RTI: next_tap = tms_e ? cpc_pkg::T_SDS : cpc_pkg::T_RTI;
            cpc_pkg::T_SDS: next_tap = tms_e ? cpc_pkg::T_SIS : cpc_pkg::T_CDR;
            cpc_pkg::T_CDR: next_tap = tms_e ? cpc_pkg::T_E1D : cpc_pkg::T_SHD;
            cpc_pkg::T_SHD: next_tap = tms_e ? cpc_pkg::T_E1D : cpc_pkg::T_SHD;
            cpc_pkg::T_E1D: next_tap = tms_e ? cpc_pkg::T_UDR : cpc_pkg::T_PDR;
            cpc_pkg::T_PDR: next_tap = tms_e ? cpc_pkg::T_E2D : cpc_pkg::T_PDR;
            cpc_pkg::T_E2D: next_tap = tms_e ? cpc_pkg::T_UDR : cpc_pkg::T_SHD;
            cpc_pkg::T_UDR: next_tap = tms_e ? cpc_pkg::T_SDS : cpc_pkg::T_RTI;
            cpc_pkg::T_SIS: next_tap = tms_e ? cpc_pkg::T_RST : cpc_pkg::T_CIR;
            cpc_pkg::T_CIR: next_tap = tms_e ? cpc_pkg::T_E1I : cpc_pkg::T_SHI;
            cpc_pkg::T_SHI: next_tap = tms_e ? cpc_pkg::T_E1I : cpc_pkg::T_SHI;
            cpc_pkg::T_E1I: next_tap = tms_e ? cpc_pkg::T_UIR : cpc_pkg::T_PIR;
            cpc_pkg::T_PIR: next_tap = tms_e ? cpc_pkg::T_E2I : cpc_pkg::T_PIR;
            cpc_pkg::T_E2I: next_tap = tms_e ? cpc_pkg::T_UIR : cpc_pkg::T_SHI;
            default:        next_tap = tms_e ? cpc_pkg::T_SDS : cpc_pkg::T_RTI;
         endcase
         case (tap)
            cpc_pkg::T_RST: next_ir = cpc_pkg::IR_IDCODE;
            cpc_pkg::T_CDR: next_dr = (ir == cpc_pkg::IR_IDCODE) ? cpc_pkg::ID_VALUE : 32'h0000_0000;
            cpc_pkg::T_SHD: begin
               if (ir == cpc_pkg::IR_IDCODE) begin
                  next_dr = {tdi_e, dr[31:1]};
               end else begin
                  next_dr = {31'h0000_0000, tdi_e};
               end
            end
            cpc_pkg::T_CIR: next_ir_sh = cpc_pkg::IR_CAPTURE;
            cpc_pkg::T_SHI: next_ir_sh = {tdi_e, ir_sh[3:1]};
            cpc_pkg::T_UIR: next_ir = ir_sh;
            default:        next_ir = ir;
         endcase
      end
      if (tck_fall) begin
         next_tdo    = (tap == cpc_pkg::T_SHI) ? ir_sh[0] : dr[0];
         next_tdo_oe = tap inside {cpc_pkg::T_SHD, cpc_pkg::T_SHI};
      end
   end

   always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         tap     <= cpc_pkg::T_RST;
         ir      <= cpc_pkg::IR_IDCODE;
         ir_sh   <= 4'h0;
         dr      <= 32'h0000_0000;
         prv_tck <= 1'b1;
         tdo     <= 1'b1;
         tdo_oe  <= 1'b0;
      end else if (clk_en_in) begin
         tap     <= next_tap;
         ir      <= next_ir;
         ir_sh   <= next_ir_sh;
         dr      <= next_dr;
         prv_tck <= next_prv_tck;
         tdo     <= next_tdo;
         tdo_oe  <= next_tdo_oe;
      end
   end

   // open-drain pins only ever pull low
   always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         config_done_od_out    <= 1'b0;
         config_data_line0_out <= 1'b0;
      end
   end

   assign config_done_od_oe_out        = done_oe;
   assign config_error_n_out           = err_n;
   assign device_select_out            = dsel_o;
   assign user_mode_out                = user;
   assign active_mode_out              = mode_act;
   assign image_index_out              = img;
   assign mode_strap_flash_cs_n_out    = cs_l;
   assign mode_strap_flash_cs_n_oe_out = cs_l_oe;
   assign upper_flash_cs_n_out         = cs_u;
   assign upper_flash_cs_n_oe_out      = cs_u_oe;
   assign config_clock_pin_out         = cko;
   assign config_clock_pin_oe_out      = cko_oe;
   assign config_data_line0_oe_out     = d0_oe;
   assign cfg_word_out                 = word;
   assign cfg_word_valid_out           = wvalid;
   assign tdo_out                      = tdo;
   assign tdo_oe_out                   = tdo_oe;

   default clocking cb @(posedge sys_clk_in); endclocking
   default disable iff (!rst_b_in);

   done_release_a: assert property ($fell(done_oe) |-> $past(image_loaded_in))
      else $error("done released without image end");
   user_wait_a: assert property ($rose(user) |-> $past(done_s) && $past(st) == cpc_pkg::C_WDONE)
      else $error("user mode entered while done line low");
   restart_a: assert property (clk_en_in && st == cpc_pkg::C_IDLE && rst_rise |=>
      st inside {cpc_pkg::C_WSEL, cpc_pkg::C_LOAD})
      else $error("reset release did not start loading");
   mode_cap_a: assert property (clk_en_in && st == cpc_pkg::C_IDLE && rst_rise |=> mode_act == $past(mode_s))
      else $error("mode strap not captured");
   image_pick_a: assert property (clk_en_in && st == cpc_pkg::C_IDLE && rst_rise |=>
      img == ($past(multi_image_in) ? $past(img_s) : 2'h0))
      else $error("image index wrong");
   word_sel_a: assert property (wvalid |-> $past(dsel_s) && $past(st) == cpc_pkg::C_LOAD)
      else $error("data taken while not selected");
   chain_sel_a: assert property ($rose(dsel_o) |-> !done_oe && user)
      else $error("chain select before completion");
   error_out_a: assert property (clk_en_in && st == cpc_pkg::C_LOAD && crc_fail_in && rst_n_s |=> !err_n)
      else $error("crc failure not flagged");
   tdo_edge_a: assert property ($changed(tdo) || $rose(tdo_oe) |-> $past(tck_fall))
      else $error("test output moved off falling edge");
   tdo_idle_a: assert property ($rose(tdo_oe) |-> tap inside {cpc_pkg::T_SHD, cpc_pkg::T_SHI})
      else $error("test output driven outside shift");

   user_c: cover property ($rose(user));
   error_c: cover property ($fell(err_n));
   word_c: cover property (wvalid && mode_act);
   tdo_c: cover property ($rose(tdo_oe));
endmodule : cpc_top

// ===== cpc_host_model.sv
// passive-mode host: drives the config clock pin and the data lines
// assumes the bench owns reconfig reset, select and the strap pins
`timescale 1ns/1ps
module cpc_host_model (
   output logic        clk_pin_out,
   output logic [31:0] data_out
);
   initial begin
      clk_pin_out = 1'h1;
      data_out    = 32'h0000_0000;
   end
   task automatic send(input logic [31:0] w, input logic wide);
      int n;
      n = wide ? 1 : 32;
      #7;
      for (int i = 0; i < n; i++) begin
         clk_pin_out = 1'h0;
         data_out = wide ? w : {32{w[31 - i]}};
         #160;
         clk_pin_out = 1'h1;
         #160;
      end
      data_out = ~data_out;
   endtask : send
   task automatic trailer();
      #7;
      repeat (100) begin
         clk_pin_out = 1'h0;
         #160;
         clk_pin_out = 1'h1;
         data_out = ~data_out;
         #160;
      end
   endtask : trailer
endmodule : cpc_host_model

// ===== tb_top.sv
// self-checking bench of the configuration pin controller
// assumes cpc_pkg, cpc_top and cpc_host_model are compiled first
`timescale 1ns/1ps
module tb_top;
   logic sys_clk_in = 1'h0, rst_b_in = 1'h0, clk_en_in = 1'h1, reconfig_reset_n_in = 1'h1, mode_pin = 1'h0;
   logic multi_image_in = 1'h1, remote_reconfig_in = 1'h0, device_select_in = 1'h1, alt_active_clock_in = 1'h0;
   logic alt_clock_sel_in = 1'h0, image_loaded_in = 1'h0, id_mismatch_in = 1'h0, crc_fail_in = 1'h0;
   logic remote_fail_in = 1'h0, tck_in = 1'h1, tms_in = 1'h0, tms_undriven_in = 1'h0, tdi_in = 1'h0;
   logic tdi_undriven_in = 1'h0, hold_low = 1'h0, host_clk;
   logic [1:0] image_select_strap_in = 2'h0, remote_image_in = 2'h0, data_width_in = 2'h0, image_index_out;
   logic [31:0] host_data, cfg_word_out, seed = 32'h0000_003d;
   logic [63:0] to, toe;
   logic config_done_od_out, config_done_od_oe_out, config_error_n_out, device_select_out, user_mode_out;
   logic active_mode_out, mode_strap_flash_cs_n_out, mode_strap_flash_cs_n_oe_out, upper_flash_cs_n_out;
   logic upper_flash_cs_n_oe_out, config_clock_pin_out, config_clock_pin_oe_out, config_data_line0_out;
   logic config_data_line0_oe_out, cfg_word_valid_out, tdo_out, tdo_oe_out;
   wire mode_strap_flash_cs_n_in = mode_strap_flash_cs_n_oe_out ? mode_strap_flash_cs_n_out : mode_pin;
   wire config_clock_pin_in = config_clock_pin_oe_out ? config_clock_pin_out : host_clk;
   wire config_done_od_in = !(config_done_od_oe_out || hold_low);
   wire [31:0] config_data_line_in = {host_data[31:1], config_data_line0_oe_out ? config_data_line0_out : host_data[0]};
   logic [31:0] exp_q[$];
   int mismatches = 0, compares = 0, ticks = 0;

   cpc_top DUT (.*);
   // no test mode pin; board holds it off
   cpc_host_model host (.clk_pin_out(host_clk), .data_out(host_data));

   initial forever #20 sys_clk_in = ~sys_clk_in;
   initial forever #160 alt_active_clock_in = ~alt_active_clock_in;

   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : xs
   task automatic check(input bit ok, input string m);
      compares++;
      if (!ok) begin
         mismatches++;
         $display("BAD %0t %s", $time, m);
      end
   endtask : check
   task automatic close_out();
      if (mismatches == 0 && compares > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : close_out
   task automatic cyc(input int n);
      repeat (n) @(posedge sys_clk_in);
   endtask : cyc
   task automatic pulse_reset();
      reconfig_reset_n_in <= 1'h0;
      cyc(4);
      reconfig_reset_n_in <= 1'h1;
      cyc(6);
   endtask : pulse_reset
   task automatic walk(input logic [63:0] m, input logic [63:0] d, input int n);
      for (int i = 0; i < n; i++) begin
         tck_in <= 1'h0;
         tms_in <= m[i];
         tdi_in <= d[i];
         cyc(8);
         to[i] = tdo_out;
         toe[i] = tdo_oe_out;
         tck_in <= 1'h1;
         cyc(8);
      end
   endtask : walk
   task automatic load(input logic [1:0] img, input logic wide, input logic sel);
      logic [31:0] w;
      image_select_strap_in <= img;
      device_select_in <= sel;
      data_width_in <= wide ? 2'h3 : 2'h0;
      mode_pin <= 1'h0;
      pulse_reset();
      check(active_mode_out === 1'h0 && config_clock_pin_oe_out === 1'h0, "passive");
      check(image_index_out === img && config_done_od_oe_out === 1'h1, "image");
      cyc(800);
      for (int k = 0; k < 2; k++) begin
         w = xs();
         if (sel) exp_q.push_back(w);
         host.send(w, wide);
         cyc(1);
      end
      cyc(10);
      check(user_mode_out === 1'h0 && config_done_od_oe_out === 1'h1, "early user");
      if (sel) begin
         image_loaded_in <= 1'h1;
         cyc(1);
         image_loaded_in <= 1'h0;
         hold_low <= 1'h1;
         host.trailer();
         cyc(1);
         check(user_mode_out === 1'h0 && config_done_od_oe_out === 1'h0, "held low");
         check(config_done_od_out === 1'h0, "done level");
         hold_low <= 1'h0;
         cyc(6);
         check(user_mode_out === 1'h1 && device_select_out === 1'h1, "user");
         check(config_data_line0_oe_out === 1'h0 && mode_strap_flash_cs_n_oe_out === 1'h0, "pins");
      end
   endtask : load

   always @(posedge sys_clk_in) begin
      if (cfg_word_valid_out === 1'h1) begin
         if (exp_q.size() == 0) check(1'h0, "extra word");
         else check(cfg_word_out === exp_q.pop_front(), "word");
      end
      ticks <= ticks + 1;
      if (ticks == 60000) begin
         mismatches++;
         close_out();
      end
   end

   initial begin
      cyc(2);
      rst_b_in <= 1'h1;
      cyc(1);
      check(config_done_od_oe_out === 1'h1 && config_error_n_out === 1'h1 && tdo_oe_out === 1'h0, "reset");
      for (int i = 0; i < 4; i++) begin
         load(2'(i), i[0], 1'h1);
         remote_image_in <= ~2'(i);
         remote_reconfig_in <= 1'h1;
         cyc(1);
         remote_reconfig_in <= 1'h0;
         cyc(8);
         check(image_index_out === ~2'(i), "remote image");
      end
      load(2'h1, 1'h0, 1'h0);
      multi_image_in <= 1'h0;
      for (int e = 0; e < 3; e++) begin
         mode_pin <= 1'h1;
         device_select_in <= 1'h1;
         data_width_in <= 2'(6'h06 >> (2 * e));
         alt_clock_sel_in <= e[0];
         pulse_reset();
         check(config_error_n_out === 1'h1 && active_mode_out === 1'h1, "active");
         check(image_index_out === 2'h0, "single image");
         check(mode_strap_flash_cs_n_out === 1'h0 && mode_strap_flash_cs_n_oe_out === 1'h1, "lower cs");
         check(upper_flash_cs_n_oe_out === (e == 0) && config_clock_pin_oe_out === 1'h1, "upper cs");
         check(upper_flash_cs_n_out === (e != 0), "upper level");
         check(config_clock_pin_out === 1'h1 || e == 1, "clock out");
         check(config_data_line0_oe_out === (e == 2) && config_data_line0_out === 1'h0, "line0");
         {id_mismatch_in, crc_fail_in, remote_fail_in} <= 3'h4 >> e;
         cyc(1);
         {id_mismatch_in, crc_fail_in, remote_fail_in} <= 3'h0;
         cyc(5);
         check(config_error_n_out === 1'h0, "error");
      end
      tdi_undriven_in <= 1'h1;
      walk(64'h0000_0000_0000_0306, 64'h0000_0000_0000_0000, 11);
      check(to[8:5] === 4'h1 && toe[5] === 1'h1, "ir capture");
      tdi_undriven_in <= 1'h0;
      walk(64'h0000_0000_0000_0c01, {32'h0000_0000, xs()}, 13);
      check(to[3] === 1'h0 && to[10:4] === seed[9:3], "bypass");
      tms_undriven_in <= 1'h1;
      walk(64'h0000_0000_0000_0000, 64'h0000_0000_0000_0000, 5);
      tms_undriven_in <= 1'h0;
      walk(64'h0000_0018_0000_0002, 64'h0000_0000_0000_0000, 38);
      check(to[35:4] === cpc_pkg::ID_VALUE, "idcode");
      check(toe[3] === 1'h0 && toe[4] === 1'h1 && toe[36] === 1'h0, "tdo drive");
      check(exp_q.size() == 0, "words left");
      close_out();
   end
endmodule : tb_top
